// >>> hdl/startup_seq.sv
// What this block does
// - Power-down low keeps everything off and serial control ignored.
// - Power-down rising edge launches power-on reset, then start-up, then running.
// - Stay in reset until supplies and power-down pin are both qualified.
// - Interface strap sampled at start-up: high selects SPI, low I2C.
// - Two three-level page straps sampled at start-up choose the ROM page.
// - Soft reset after settling restarts VCO calibration and PLL start-up.
// - Third analog PLL skips calibration, locks on valid oscillator reference.
`timescale 1ns/100ps
`default_nettype none
`include "startup_defs.svh"

module startup_seq
   import startup_pkg::*;
#(
   parameter int CAL_CYCLES = `CAL_CYCLES_DEF
) (
   input  wire logic                CLK_SYS_IN,
   input  wire logic                RSTN_IN,
   input  wire logic                POWER_DOWN_N_IN,
   input  wire logic                SUPPLY_OK_IN,
   input  wire logic                PD_ABOVE_VIH_IN,
   input  wire logic                INTERFACE_SELECT_STRAP_IN,
   input  wire logic [1:0]          ROM_PAGE_STRAP_LOW_IN,
   input  wire logic [1:0]          ROM_PAGE_STRAP_HIGH_IN,
   input  wire logic                SOFT_RESET_BIT_IN,
   input  wire logic                OSC_VALID_IN,
   input  wire logic                CAL_DONE_IN,
   output logic                     POWERED_OUT,
   output logic                     SERIAL_ENABLE_OUT,
   output logic                     SPI_SELECT_OUT,
   output logic [`PAGE_W-1:0]       ROM_PAGE_OUT,
   output logic                     ROM_LOAD_OUT,
   output logic                     CAL_START_OUT,
   output logic                     PLL_LOCK_ENABLE_OUT,
   output logic                     THIRD_PLL_ENABLE_OUT,
   output logic                     THIRD_DPLL_REF_OK_OUT,
   output logic                     RUNNING_OUT
);
   logic rst_s1;
   logic rst_n;
   // reset released through two flops, asserted at once
   always_ff @(posedge CLK_SYS_IN or negedge RSTN_IN) begin
      if (!RSTN_IN) begin
         rst_s1 <= 1'b0;
         rst_n  <= 1'b0;
      end else begin
         rst_s1 <= 1'b1;
         rst_n  <= rst_s1;
      end
   end

   logic pd_n;
   pd_filter u_pd_filter (
      .clk_in      (CLK_SYS_IN),
      .rst_n_in    (rst_n),
      .pin_n_in    (POWER_DOWN_N_IN),
      .level_n_out (pd_n)
   );

   // pin-side inputs all pass two flops before use
   localparam int PW = 8;
   logic [PW-1:0] pin_s1;
   logic [PW-1:0] pin_s2;
   logic [PW-1:0] pin_raw;
   assign pin_raw = {SUPPLY_OK_IN, PD_ABOVE_VIH_IN, INTERFACE_SELECT_STRAP_IN, ROM_PAGE_STRAP_LOW_IN,
                     ROM_PAGE_STRAP_HIGH_IN, OSC_VALID_IN};
   always_ff @(posedge CLK_SYS_IN or negedge rst_n) begin
      if (!rst_n) begin
         pin_s1 <= '0;
         pin_s2 <= '0;
      end else begin
         pin_s1 <= pin_raw;
         pin_s2 <= pin_s1;
      end
   end
   logic       supply_ok;
   logic       pd_vih;
   logic       if_strap;
   logic [1:0] pg_lo;
   logic [1:0] pg_hi;
   logic       osc_valid;
   assign {supply_ok, pd_vih, if_strap, pg_lo, pg_hi, osc_valid} = pin_s2;

   // soft-reset edge: the bit is set by same-clock logic
   logic swr_d;
   logic swr_rise;
   assign swr_rise = SOFT_RESET_BIT_IN && !swr_d;

   seq_state_type             state;
   seq_state_type             next_state;
   logic                      spi_sel;
   logic                      next_spi_sel;
   logic [`PAGE_W-1:0]        page;
   logic [`PAGE_W-1:0]        next_page;
   logic                      rom_load;
   logic                      next_rom_load;
   logic                      cal_start;
   logic                      next_cal_start;
   logic [`CAL_CNT_W-1:0]     cal_cnt;
   logic [`CAL_CNT_W-1:0]     next_cal_cnt;
   logic                      dref_ok;
   logic                      next_dref_ok;

   // sequencer next-state; a power-down low wins from any state
   always_comb begin
      next_state     = state;
      next_spi_sel   = spi_sel;
      next_page      = page;
      next_rom_load  = 1'b0;
      next_cal_start = 1'b0;
      next_cal_cnt   = cal_cnt;
      next_dref_ok   = dref_ok && osc_valid;
      if (!pd_n) begin
         next_state   = ST_POWERED_DOWN;
         next_dref_ok = 1'b0;
      end else begin
         case (state)
            ST_POWERED_DOWN: begin
               next_state = ST_POR_WAIT;
            end
            ST_POR_WAIT: begin
               if (supply_ok && pd_vih) begin
                  next_state = ST_SAMPLE;
               end
            end
            ST_SAMPLE: begin
               next_spi_sel  = if_strap;
               // base-three page index from the two straps
               next_page     = `PAGE_W'(pg_hi) * `PAGE_RADIX + `PAGE_W'(pg_lo);
               next_rom_load = 1'b1;
               next_state    = ST_CALIBRATE;
               next_cal_start = 1'b1;
               next_cal_cnt  = '0;
            end
            ST_CALIBRATE: begin
               // limit: the count runs on even if the oscillator was bad
               next_cal_cnt = cal_cnt + `CAL_CNT_W'(1);
               if (CAL_DONE_IN || cal_cnt >= `CAL_CNT_W'(CAL_CYCLES - 1)) begin
                  next_state = ST_RUN;
               end
            end
            ST_RUN: begin
               if (swr_rise) begin
                  next_state = ST_SOFT_RESET;
               end
               if (osc_valid) begin
                  next_dref_ok = 1'b1;
               end
            end
            ST_SOFT_RESET: begin
               next_state     = ST_CALIBRATE;
               next_cal_start = 1'b1;
               next_cal_cnt   = '0;
            end
            default: begin
               next_state = ST_POWERED_DOWN;
            end
         endcase
      end
   end

   always_ff @(posedge CLK_SYS_IN or negedge rst_n) begin
      if (!rst_n) begin
         state     <= ST_POWERED_DOWN;
         spi_sel   <= 1'b0;
         page      <= '0;
         rom_load  <= 1'b0;
         cal_start <= 1'b0;
         cal_cnt   <= '0;
         dref_ok   <= 1'b0;
         swr_d     <= 1'b0;
      end else begin
         state     <= next_state;
         spi_sel   <= next_spi_sel;
         page      <= next_page;
         rom_load  <= next_rom_load;
         cal_start <= next_cal_start;
         cal_cnt   <= next_cal_cnt;
         dref_ok   <= next_dref_ok;
         swr_d     <= SOFT_RESET_BIT_IN;
      end
   end

   // registered outputs, decoded one cycle after the state
   always_ff @(posedge CLK_SYS_IN or negedge rst_n) begin
      if (!rst_n) begin
         POWERED_OUT           <= 1'b0;
         SERIAL_ENABLE_OUT     <= 1'b0;
         SPI_SELECT_OUT        <= 1'b0;
         ROM_PAGE_OUT          <= '0;
         ROM_LOAD_OUT          <= 1'b0;
         CAL_START_OUT         <= 1'b0;
         PLL_LOCK_ENABLE_OUT   <= 1'b0;
         THIRD_PLL_ENABLE_OUT  <= 1'b0;
         THIRD_DPLL_REF_OK_OUT <= 1'b0;
         RUNNING_OUT           <= 1'b0;
      end else begin
         POWERED_OUT           <= (state != ST_POWERED_DOWN);
         SERIAL_ENABLE_OUT     <= (state == ST_RUN) || (state == ST_CALIBRATE) || (state == ST_SOFT_RESET);
         SPI_SELECT_OUT        <= spi_sel;
         ROM_PAGE_OUT          <= page;
         ROM_LOAD_OUT          <= rom_load;
         CAL_START_OUT         <= cal_start;
         PLL_LOCK_ENABLE_OUT   <= (state == ST_RUN);
         // no calibration for the third pll, it just waits for the oscillator
         THIRD_PLL_ENABLE_OUT  <= (state != ST_POWERED_DOWN) && (state != ST_POR_WAIT) && osc_valid;
         THIRD_DPLL_REF_OK_OUT <= dref_ok && osc_valid;
         RUNNING_OUT           <= (state == ST_RUN);
      end
   end

   AST_PD_LOW_SHUTS: assert property (@(posedge CLK_SYS_IN) disable iff (!rst_n)
      !pd_n |-> ##2 (!POWERED_OUT && !SERIAL_ENABLE_OUT))
      else $error("device active during power-down");
   AST_POR_ON_RISE: assert property (@(posedge CLK_SYS_IN) disable iff (!rst_n)
      (state == ST_POWERED_DOWN && pd_n) |=> state == ST_POR_WAIT)
      else $error("power-down release did not start por");
   AST_POR_QUAL: assert property (@(posedge CLK_SYS_IN) disable iff (!rst_n)
      (state == ST_POR_WAIT && !(supply_ok && pd_vih)) |=> state != ST_SAMPLE)
      else $error("start-up without qualified supplies");
   AST_IF_STRAP: assert property (@(posedge CLK_SYS_IN) disable iff (!rst_n)
      (state == ST_SAMPLE && pd_n) |-> ##2 SPI_SELECT_OUT == $past(if_strap, 2))
      else $error("interface strap not captured");
   AST_PAGE_LOAD: assert property (@(posedge CLK_SYS_IN) disable iff (!rst_n)
      (state == ST_SAMPLE && pd_n) |-> ##2 (ROM_LOAD_OUT && ROM_PAGE_OUT < `PAGE_COUNT))
      else $error("rom page not loaded");
   AST_SOFT_RECAL: assert property (@(posedge CLK_SYS_IN) disable iff (!rst_n)
      (state == ST_RUN && swr_rise && pd_n) |-> ##[3:4] CAL_START_OUT)
      else $error("soft reset did not restart calibration");
   AST_DREF_NEEDS_OSC: assert property (@(posedge CLK_SYS_IN) disable iff (!rst_n)
      THIRD_DPLL_REF_OK_OUT |-> $past(osc_valid))
      else $error("digital pll reference validated without oscillator");
endmodule
`default_nettype wire

// >>> hdl/startup_defs.svh
`ifndef STARTUP_DEFS_SVH
`define STARTUP_DEFS_SVH

// minimum captured low pulse on the power-down pin
`define PD_MIN_LOW_NS      200
`define CLK_PERIOD_NS      50
// cycles of settled low needed before the low counts (rounded down, at least one)
`define PD_FILT_CYCLES     ((`PD_MIN_LOW_NS / `CLK_PERIOD_NS) > 1 ? (`PD_MIN_LOW_NS / `CLK_PERIOD_NS) : 1)
`define PD_CNT_W           4
// default calibration length, cycles
`define CAL_CYCLES_DEF     64
`define CAL_CNT_W          16
// three-level strap encodings
`define STRAP_LOW          2'h0
`define STRAP_MID          2'h1
`define STRAP_HIGH         2'h2
`define PAGE_W             4
`define PAGE_RADIX         4'h3
// number of legal pages from two three-level straps
`define PAGE_COUNT         4'h9

`endif

// >>> hdl/startup_pkg.sv
`default_nettype none
package startup_pkg;
   typedef enum logic [5:0] {
      ST_POWERED_DOWN = 6'h01,
      ST_POR_WAIT     = 6'h02,
      ST_SAMPLE       = 6'h04,
      ST_CALIBRATE    = 6'h08,
      ST_RUN          = 6'h10,
      ST_SOFT_RESET   = 6'h20
   } seq_state_type;
endpackage
`default_nettype wire

// >>> hdl/pd_filter.sv
`timescale 1ns/100ps
`default_nettype none
`include "startup_defs.svh"

// synchronises the power-down pin and rejects lows too short to capture
module pd_filter #(
   parameter int FILT_CYCLES = `PD_FILT_CYCLES
) (
   input  wire logic clk_in,
   input  wire logic rst_n_in,
   input  wire logic pin_n_in,
   output logic      level_n_out
);
   logic                 sync1;
   logic                 sync2;
   logic [`PD_CNT_W-1:0] cnt;
   logic [`PD_CNT_W-1:0] next_cnt;
   logic                 level_n;
   logic                 next_level_n;

   // filter: only a low that stands FILT_CYCLES counts, a high counts at once
   always_comb begin
      next_cnt     = cnt;
      next_level_n = level_n;
      if (sync2) begin
         next_cnt     = '0;
         next_level_n = 1'b1;
      end else if (cnt >= `PD_CNT_W'(FILT_CYCLES - 1)) begin
         next_level_n = 1'b0;
      end else begin
         next_cnt = cnt + `PD_CNT_W'(1);
      end
   end

   // sync1 only feeds sync2
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         sync1   <= 1'b0;
         sync2   <= 1'b0;
         cnt     <= '0;
         level_n <= 1'b0;
      end else begin
         sync1   <= pin_n_in;
         sync2   <= sync1;
         cnt     <= next_cnt;
         level_n <= next_level_n;
      end
   end

   assign level_n_out = level_n;

   // a low only counts after the synchronised pin stood low four samples in a row
   AST_SHORT_LOW_IGNORED: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      $fell(level_n) |-> (!$past(sync2, 1) && !$past(sync2, 2) && !$past(sync2, 3) && !$past(sync2, 4)))
      else $error("low pulse taken without filtering");
endmodule
`default_nettype wire

// >>> test/host_model.sv
`timescale 1ns/100ps
`default_nettype none
// host side: drives the power-down pin and the soft-reset bit
module host_model (
   input  wire logic       clk_in,
   input  wire logic       supply_ok_in,
   input  wire logic       osc_valid_in,
   input  wire logic       pulse_req_in,
   input  wire logic [3:0] pulse_len_in,
   input  wire logic       soft_req_in,
   output logic            pd_n_out,
   output logic            soft_bit_out
);
   logic       released;
   logic [3:0] low_cnt;

   // pin starts low, device off
   initial begin
      released = 1'b0;
      low_cnt = 4'h0;
      pd_n_out = 1'b0;
      soft_bit_out = 1'b0;
   end

   // first release waits for settled supplies and a stable oscillator
   always @(posedge clk_in) begin
      released <= released | (supply_ok_in & osc_valid_in);
      if (pulse_req_in) begin
         low_cnt <= pulse_len_in;
      end else if (low_cnt != 4'h0) begin
         low_cnt <= low_cnt - 4'h1;
      end
      // low for exactly pulse_len cycles; short lengths only when a test asks
      pd_n_out <= #2 released & ~pulse_req_in & (low_cnt <= 4'h1);
      // one-cycle bit; sync bit set/clear is left to the register writer
      soft_bit_out <= #2 soft_req_in;
   end
endmodule
`default_nettype wire

// >>> test/tb_powerdown_por_strap_startup.sv
`timescale 1ns/100ps
`default_nettype none
module tb_powerdown_por_strap_startup;
   logic       clk, rst_n, sup, vih, spi, osc, cal, preq, sreq, pd_n, sbit;
   logic       pwr, ser, spi_o, rld, cst, lock, p3, d3, run;
   logic [1:0] lo, hi;
   logic [3:0] plen, page;
   int         errors, checked, cyc;

   startup_seq #(.CAL_CYCLES(64)) dut (
      .CLK_SYS_IN(clk), .RSTN_IN(rst_n), .POWER_DOWN_N_IN(pd_n), .SUPPLY_OK_IN(sup),
      .PD_ABOVE_VIH_IN(vih), .INTERFACE_SELECT_STRAP_IN(spi), .ROM_PAGE_STRAP_LOW_IN(lo),
      .ROM_PAGE_STRAP_HIGH_IN(hi), .SOFT_RESET_BIT_IN(sbit), .OSC_VALID_IN(osc),
      .CAL_DONE_IN(cal), .POWERED_OUT(pwr), .SERIAL_ENABLE_OUT(ser), .SPI_SELECT_OUT(spi_o),
      .ROM_PAGE_OUT(page), .ROM_LOAD_OUT(rld), .CAL_START_OUT(cst), .PLL_LOCK_ENABLE_OUT(lock),
      .THIRD_PLL_ENABLE_OUT(p3), .THIRD_DPLL_REF_OK_OUT(d3), .RUNNING_OUT(run));

   host_model host (
      .clk_in(clk), .supply_ok_in(sup), .osc_valid_in(osc), .pulse_req_in(preq),
      .pulse_len_in(plen), .soft_req_in(sreq), .pd_n_out(pd_n), .soft_bit_out(sbit));

   // 20 MHz clock
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   // hang guard, well above the expected run length
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         errors++;
         print_verdict();
      end
   end

   task automatic print_verdict();
      $display("errors %0d checked %0d", errors, checked);
      if (errors == 0 && checked > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   // inputs change and outputs are read 2 ns after the edge
   task automatic tick(input int n = 1);
      repeat (n) begin
         @(posedge clk);
         #2;
      end
   endtask

   task automatic chk(input logic [3:0] got, input logic [3:0] exp, input string msg);
      checked++;
      if (got !== exp) begin
         errors++;
         $display("BAD %0t %s", $time, msg);
      end
   endtask

   // bounded wait; a one-cycle pulse is caught because every cycle is looked at
   task automatic wait_for(ref logic sig, input logic val, input string msg);
      int n;
      n = 0;
      while (sig !== val && n < 100) begin
         tick();
         n++;
      end
      chk(4'(sig), 4'(val), msg);
   endtask

   task automatic pd_pulse(input logic [3:0] len);
      plen = len;
      preq = 1'b1;
      tick();
      preq = 1'b0;
   endtask

   // power-down pulse with given straps, then full start-up
   task automatic power_cycle(input logic s, input logic [1:0] l, input logic [1:0] h);
      spi = s;
      lo = l;
      hi = h;
      pd_pulse(4'h8);
      wait_for(pwr, 1'b0, "no power down");
      chk(4'(ser), 4'h0, "serial on while down");
      chk(4'(run), 4'h0, "running while down");
      wait_for(rld, 1'b1, "no rom load");
      chk(page, 4'(h) * 4'h3 + 4'(l), "rom page");
      chk(4'(spi_o), 4'(s), "interface select");
      chk(4'(cst), 4'h1, "no cal start");
      cal = 1'b1;
      wait_for(run, 1'b1, "not running");
      cal = 1'b0;
      // digital pll reference flag trails the run state by one cycle
      tick();
      chk({lock, ser, p3, d3}, 4'hf, "run outputs");
   endtask

   task automatic t_straps();
      for (int i = 0; i < 9; i++) power_cycle(i[0], 2'(i % 3), 2'(i / 3));
   endtask

   task automatic t_glitch();
      pd_pulse(4'h2);
      repeat (15) begin
         tick();
         chk(4'(run), 4'h1, "short low acted");
      end
   endtask

   task automatic t_soft();
      sreq = 1'b1;
      tick();
      sreq = 1'b0;
      wait_for(cst, 1'b1, "soft reset no cal");
      chk(4'(run), 4'h0, "still running");
      wait_for(run, 1'b1, "no run after cal count");
   endtask

   task automatic t_osc();
      osc = 1'b0;
      tick(6);
      chk({p3, d3}, 4'h0, "third pll without osc");
      osc = 1'b1;
      tick(6);
      chk({p3, d3}, 4'h3, "third pll not back");
   endtask

   task automatic t_vih();
      vih = 1'b0;
      pd_pulse(4'h8);
      wait_for(pwr, 1'b0, "no power down");
      tick(30);
      chk({ser, run}, 4'h0, "start-up without pin qualified");
      vih = 1'b1;
      wait_for(rld, 1'b1, "no rom load");
      cal = 1'b1;
      wait_for(run, 1'b1, "not running");
      cal = 1'b0;
   endtask

   // main sequence
   initial begin
      rst_n = 1'b0;
      {sup, vih, spi, osc, cal, preq, sreq} = 7'h20;
      lo = 2'h0;
      hi = 2'h0;
      plen = 4'h0;
      errors = 0;
      checked = 0;
      cyc = 0;
      tick(4);
      rst_n = 1'b1;
      tick(10);
      chk({pwr, ser}, 4'h0, "up before supplies");
      sup = 1'b1;
      osc = 1'b1;
      t_straps();
      t_glitch();
      t_soft();
      t_osc();
      t_vih();
      print_verdict();
   end
endmodule
`default_nettype wire
